//--- ebsc_ctrl.sv
// external bus state controller: apb registers, arbiter and bus sequencer
// assumes synchronous pin inputs and requests that hold until done pulses
//
// Overview of operation
// [R01] top eight address bits select space, never output
// [R02] space zero decodes bits 23:22 into select; code drives one select from bits 31:24 only
// [R03] only address bits 17:0 reach the pins
// [R04] plain access takes exactly two states
// [R05] reads capture all eight data bits
// [R06] writes assert lower byte strobe
// [R07] programmed wait states added per access
// [R08] wait pin sampled one cycle before exit
// [R09] software programs enough waits for wait pin
// [R10] extension adds select-only cycle each side
// [R11] write data held through trailing extension
// [R12] read then write guarantees idle count
// [R13] same space back-to-back inserts idle cycles
// [R14] read-write same space uses larger idle
// [R15] fixed priority external, trace, transfer, core
// [R16] request finishes cycle, releases, then acknowledges
// [R17] test-and-set halves never separated
// [R18] wide access split into indivisible bytes
// [R19] interrupt pending asserted while bus released
// [R20] external master drops request on pending
// [R21] instruction fetch always reads thirty-two bits
// [R22] software writes size field once only
// [R23] acknowledge drops, bus resumes next cycle
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module ebsc_ctrl
	import ebsc_pkg::*;
#(
	parameter int NUM_MASTERS = 3
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_b,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// internal masters: 0 core, 1 transfer ctrl, 2 debug trace
	input  wire logic [NUM_MASTERS-1:0] masterReq,
	input  wire ebsc_req_s              masterCmd [NUM_MASTERS],
	input  wire logic                   fetchReq,
	output logic      [NUM_MASTERS-1:0] masterDone,
	output logic      [31:0]            readData,
	// external pins
	output ebsc_pins_s                  pins,
	input  wire logic [7:0]             dataIn,
	input  wire logic                   wait_n,
	input  wire logic                   external_bus_request_n,
	output logic                        busAck_n,
	// interrupt level compare
	input  wire logic                   intSourceValid,
	input  wire logic [3:0]             intLevel,
	input  wire logic [3:0]             interrupt_mask_bits,
	output logic                        interrupt_pending_out_n
);
	typedef enum {ST_IDLE, ST_GAP, ST_HEAD, ST_T1, ST_TW, ST_T2, ST_TAIL, ST_REL} ebsc_state_e;

	logic [15:0]            bus_control_one;
	logic [15:0]            bus_control_two;
	logic [15:0]            wait_control_one;
	logic [15:0]            ram_emulation_select;
	ebsc_state_e            state;
	logic [1:0]             owner;
	logic                   active;
	ebsc_req_s              cur;
	logic [1:0]             byteIdx;
	logic [1:0]             lastByte;
	logic [WAIT_CNT_W-1:0]  waitCnt;
	logic [1:0]             gapCnt;
	logic [1:0]             idleSeen;
	logic                   prevValid;
	logic                   prevRead;
	logic [1:0]             prevArea;
	logic                   locked;
	logic                   grantOk;
	logic [1:0]             next_owner;
	logic [1:0]             pick;
	logic [1:0]             needGap;
	logic [31:0]            effAddr;
	logic                   selExt;
	logic [WAIT_CNT_W-1:0]  waitSet;

	assign selExt  = bus_control_two[SEL_EXTEND_POS];
	assign waitSet = wait_control_one[WAIT_CNT_POS +: WAIT_CNT_W];
	// a locked owner keeps the bus, else the arbiter's choice
	assign pick    = locked ? owner : next_owner;

	// read-write idle count from two bits
	function automatic logic [1:0] rwIdle(input logic [15:0] r);
		rwIdle = {r[RW_IDLE_HI_POS], r[RW_IDLE_LO_POS]};
	endfunction : rwIdle

	// bytes per access, fetch widened to a longword
	function automatic logic [1:0] lastOf(input ebsc_size_e s, input logic f);
		if (f || s == EBSC_SZ_LONG) begin
			lastOf = 2'd3;
		end else if (s == EBSC_SZ_WORD) begin
			lastOf = 2'd1;
		end else begin
			lastOf = 2'd0;
		end
	endfunction : lastOf

	// apb slave, zero wait, unmapped reads zero with error
	assign pready = 1'b1;
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		unique case (paddr)
			BUS_CTRL_ONE_OFS:  prdata = {16'h0000, bus_control_one};
			BUS_CTRL_TWO_OFS:  prdata = {16'h0000, bus_control_two};
			WAIT_CTRL_ONE_OFS: prdata = {16'h0000, wait_control_one};
			RAM_EMU_SEL_OFS:   prdata = {16'h0000, ram_emulation_select};
			STATUS_OFS:        prdata = {28'h0000000, ~busAck_n, active, owner};
			default:           pslverr = psel & penable;
		endcase
	end

	// register writes
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			bus_control_one      <= BUS_CTRL_ONE_RST;
			bus_control_two      <= BUS_CTRL_TWO_RST;
			wait_control_one     <= WAIT_CTRL_ONE_RST;
			ram_emulation_select <= RAM_EMU_SEL_RST;
		end else if (psel && penable && pwrite) begin
			unique case (paddr)
				// [R22] size field written freely, software writes once
				BUS_CTRL_ONE_OFS:  bus_control_one      <= pwdata[15:0];
				BUS_CTRL_TWO_OFS:  bus_control_two      <= pwdata[15:0];
				WAIT_CTRL_ONE_OFS: wait_control_one     <= pwdata[15:0];
				RAM_EMU_SEL_OFS:   ram_emulation_select <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// [R15] fixed priority arbiter
	always_comb begin
		next_owner = 2'd0;
		grantOk    = 1'b0;
		if (external_bus_request_n) begin
			for (int i = 0; i < NUM_MASTERS; i++) begin
				if (masterReq[i] && !masterDone[i]) begin // done master not taken again
					next_owner = 2'(i);
					grantOk    = 1'b1;
				end
			end
		end
	end

	// [R12] [R13] [R14] idle gap needed before the next access
	always_comb begin
		logic [1:0] want;
		want = 2'd0;
		if (prevValid && prevRead && masterCmd[pick].write) begin
			want = rwIdle(bus_control_two);
		end
		if (prevValid && prevArea == masterCmd[pick].addr[AREA_HI:AREA_LO]
			&& {1'b0, bus_control_two[SAME_IDLE_POS]} > want && idleSeen == 2'd0) begin
			want = {1'b0, bus_control_two[SAME_IDLE_POS]};
		end
		needGap = (want > idleSeen) ? 2'(want - idleSeen) : 2'd0;
	end

	// [R01] space field ignored on pins, area from current request
	assign effAddr = {8'h00, cur.addr[AREA_HI:0]} + {30'h0, byteIdx};

	// bus sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state      <= ST_IDLE;
			active     <= 1'b0;
			owner      <= 2'd0;
			cur        <= '0;
			byteIdx    <= 2'd0;
			lastByte   <= 2'd0;
			waitCnt    <= '0;
			gapCnt     <= 2'd0;
			idleSeen   <= 2'd3;
			prevValid  <= 1'b0;
			prevRead   <= 1'b0;
			prevArea   <= 2'd0;
			locked     <= 1'b0;
			masterDone <= '0;
			readData   <= 32'h0000_0000;
			busAck_n   <= 1'b1;
		end else begin
			masterDone <= '0;
			unique case (state)
				ST_IDLE: begin
					if (idleSeen != 2'd3) begin
						idleSeen <= idleSeen + 2'd1;
					end
					// [R16] release only between bus cycles
					if (!external_bus_request_n && !locked) begin
						state    <= ST_REL;
						busAck_n <= 1'b0;
					end else if (locked ? masterReq[owner] && !masterDone[owner] : grantOk) begin
						owner    <= pick;
						cur      <= masterCmd[pick];
						// [R21] fetch always a longword
						lastByte <= lastOf(masterCmd[pick].size, fetchReq && pick == 2'd0);
						byteIdx  <= 2'd0;
						active   <= 1'b1;
						gapCnt   <= needGap;
						state    <= (needGap != 2'd0) ? ST_GAP : (selExt ? ST_HEAD : ST_T1);
					end
				end
				ST_GAP: begin
					gapCnt <= gapCnt - 2'd1;
					if (gapCnt == 2'd1) begin
						state <= selExt ? ST_HEAD : ST_T1;
					end
				end
				// [R10] leading select-only cycle
				ST_HEAD: state <= ST_T1;
				// [R04] first of two basic states
				ST_T1: begin
					waitCnt <= waitSet;
					state   <= (waitSet != '0) ? ST_TW : ST_T2;
				end
				// [R07] [R08] software waits, pin sampled at the next-to-last
				ST_TW: begin
					if (waitCnt > 1) begin
						waitCnt <= waitCnt - 1'b1;
					end else if (waitCnt == 1) begin
						waitCnt <= wait_n ? '0 : waitCnt;
					end
					if (waitCnt == '0 || (waitCnt == 1 && wait_n)) begin
						state <= ST_T2;
					end
				end
				ST_T2: begin
					// [R05] all eight bits captured on read
					if (!cur.write) begin
						readData[8*byteIdx +: 8] <= dataIn;
					end
					// [R18] bytes of one cycle run with no arbitration
					if (selExt) begin
						state <= ST_TAIL; // next byte chosen after the tail
					end else if (byteIdx != lastByte) begin
						byteIdx <= byteIdx + 2'd1;
						state   <= ST_T1;
					end else begin
						state <= ST_IDLE;
					end
					if (!selExt && byteIdx == lastByte) begin
						masterDone[owner] <= 1'b1;
						active            <= 1'b0;
						// [R17] keep the bus after a test-and-set read
						locked            <= cur.lockNext;
					end
					prevValid <= 1'b1;
					prevRead  <= !cur.write;
					prevArea  <= cur.addr[AREA_HI:AREA_LO];
					idleSeen  <= 2'd0;
				end
				// [R10] [R11] trailing select-only cycle, data held
				ST_TAIL: begin
					// with extension on, byte index moves only here so the tail keeps the old byte
					if (byteIdx != lastByte) begin
						byteIdx <= byteIdx + 2'd1;
						state   <= ST_HEAD;
					end else begin
						state             <= ST_IDLE;
						masterDone[owner] <= 1'b1;
						active            <= 1'b0;
						locked            <= cur.lockNext;
					end
				end
				// [R23] acknowledge drops, drive resumes next cycle
				ST_REL: begin
					if (external_bus_request_n) begin
						busAck_n  <= 1'b1;
						state     <= ST_IDLE;
						prevValid <= 1'b0;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// external pins from state
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pins <= '{addr: '0, spaceZeroSelect_n: 1'b1, read_n: 1'b1,
				lowerByteWrite_n: 1'b1, dataOut: 8'h00, dataOe_n: 1'b1};
		end else begin
			// [R03] address 17:0 only
			pins.addr <= effAddr[EXT_ADDR_W-1:0];
			// [R02] select for space zero only
			pins.spaceZeroSelect_n <= !((state == ST_HEAD || state == ST_T1 || state == ST_TW
				|| (state == ST_T2 && !(byteIdx == lastByte && !selExt)))
				&& cur.addr[SPACE_HI:SPACE_LO] == 8'h00);
			pins.read_n <= !(!cur.write && (state == ST_T1 || state == ST_TW));
			// [R06] lower byte strobe on writes
			pins.lowerByteWrite_n <= !(cur.write && (state == ST_T1 || state == ST_TW));
			pins.dataOut  <= cur.wdata[8*byteIdx +: 8];
			// [R11] drive data through trailing cycle
			pins.dataOe_n <= !(cur.write && (state == ST_T1 || state == ST_TW
				|| (state == ST_T2 && selExt)));
		end
	end

	// [R19] pending request while bus is released
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			interrupt_pending_out_n <= 1'b1;
		end else begin
			interrupt_pending_out_n <= !(!busAck_n && intSourceValid && intLevel > interrupt_mask_bits);
		end
	end

	// plain access two states with no waits
	plain_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R04]
		state == ST_T1 && waitSet == '0 |=> state == ST_T2) else $error("access not two states");
	// wait count respected
	wait_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R07]
		state == ST_T1 && waitSet == 4'd2 |=> state == ST_TW [*2]) else $error("waits short");
	// wait pin extends
	pin_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
		state == ST_TW && waitCnt == 1 && !wait_n |=> state == ST_TW) else $error("pin wait lost");
	// extension head
	ext_head_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
		state == ST_HEAD |=> state == ST_T1) else $error("head not one cycle");
	// strobes never both
	one_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R06]
		!(!pins.read_n && !pins.lowerByteWrite_n)) else $error("both strobes");
	// ack only when released
	ack_rel_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
		!busAck_n |-> state == ST_REL && !active) else $error("ack while busy");
	// ack drop on request release
	ack_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R23]
		state == ST_REL && external_bus_request_n |=> busAck_n) else $error("ack stuck");
	// pending only when released
	irq_rel_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R19]
		!interrupt_pending_out_n |-> $past(!busAck_n)) else $error("pending while owned");
	// no release mid transfer
	no_split_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R18]
		state == ST_T2 && byteIdx != lastByte |=> state != ST_REL) else $error("split cycle");
	// write data still driven in the tail
	tail_data_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
		state == ST_TAIL && cur.write |-> !pins.dataOe_n) else $error("tail data dropped");
	// strobes stay off after the tail
	tail_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
		state == ST_TAIL |=> pins.read_n && pins.lowerByteWrite_n) else $error("strobe in tail");
	// select negated through idle gaps
	gap_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R13]
		state == ST_GAP |-> pins.spaceZeroSelect_n) else $error("select in gap");
	// locked owner never gives the bus away
	lock_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
		locked |-> busAck_n) else $error("bus released while locked");
	// pending raised when a higher level arrives
	pend_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R19]
		!busAck_n && intSourceValid && intLevel > interrupt_mask_bits
		|=> !interrupt_pending_out_n) else $error("pending missed");
	// fetch granted as a longword
	fetch_long_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R21]
		state == ST_IDLE && !locked && grantOk && fetchReq && next_owner == 2'd0
		|=> lastByte == 2'd3) else $error("fetch not four bytes");

	cover_read_c:  cover property (@(posedge sys_clk) state == ST_T2 && !cur.write);
	cover_write_c: cover property (@(posedge sys_clk) state == ST_T2 && cur.write && selExt);
	cover_rel_c:   cover property (@(posedge sys_clk) !busAck_n);
	cover_gap_c:   cover property (@(posedge sys_clk) state == ST_GAP);
	cover_tail_c:  cover property (@(posedge sys_clk) state == ST_TAIL && byteIdx != lastByte);
endmodule : ebsc_ctrl

//--- ebsc_pkg.sv
// package for the external bus state controller
// assumes a single system clock and an apb register port
package ebsc_pkg;
	// register byte offsets on the apb port
	localparam logic [7:0] BUS_CTRL_ONE_OFS   = 8'h00;
	localparam logic [7:0] BUS_CTRL_TWO_OFS   = 8'h04;
	localparam logic [7:0] WAIT_CTRL_ONE_OFS  = 8'h08;
	localparam logic [7:0] RAM_EMU_SEL_OFS    = 8'h0c;
	localparam logic [7:0] STATUS_OFS         = 8'h10;
	// reset values
	localparam logic [15:0] BUS_CTRL_ONE_RST  = 16'h0000;
	localparam logic [15:0] BUS_CTRL_TWO_RST  = 16'h0000;
	localparam logic [15:0] WAIT_CTRL_ONE_RST = 16'h0000;
	localparam logic [15:0] RAM_EMU_SEL_RST   = 16'h0000;
	// field positions in bus_control_two
	localparam int RW_IDLE_LO_POS  = 0;
	localparam int RW_IDLE_HI_POS  = 1;
	localparam int SAME_IDLE_POS   = 2;
	localparam int SEL_EXTEND_POS  = 3;
	// field positions in wait_control_one (4-bit count)
	localparam int WAIT_CNT_POS    = 0;
	localparam int WAIT_CNT_W      = 4;
	// address fields
	localparam int SPACE_HI        = 31;
	localparam int SPACE_LO        = 24;
	localparam int AREA_HI         = 23;
	localparam int AREA_LO         = 22;
	localparam int EXT_ADDR_W      = 18;

	// bus master sizes
	typedef enum logic [1:0] {
		EBSC_SZ_BYTE,
		EBSC_SZ_WORD,
		EBSC_SZ_LONG
	} ebsc_size_e;

	// one internal request
	typedef struct packed {
		logic        write;
		logic        lockNext;   // keep the bus for the next request (test-and-set read)
		ebsc_size_e  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ebsc_req_s;

	// external bus pins
	typedef struct packed {
		logic [EXT_ADDR_W-1:0] addr;
		logic                  spaceZeroSelect_n;
		logic                  read_n;
		logic                  lowerByteWrite_n;
		logic [7:0]            dataOut;
		logic                  dataOe_n;
	} ebsc_pins_s;
endpackage : ebsc_pkg

//--- ebsc_mem_model.sv
// byte wide external memory on the space zero pins
// assumes registered pins from the bus controller on the same clock
`timescale 1ns/100ps
module ebsc_mem_model
	import ebsc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire ebsc_pins_s pins,
	input  wire logic       slowMode,
	output logic [7:0]      dataIn,
	output logic            wait_n
);
	logic [7:0] mem [256];
	logic [7:0] lastD  = 8'h00;
	logic [2:0] selCnt = 3'h0;
	wire logic  rdOn   = !pins.spaceZeroSelect_n && !pins.read_n;

	assign dataIn = rdOn ? mem[pins.addr[7:0]] : ~lastD; // idle bus shows inverse

	always_ff @(posedge sys_clk) begin
		if (!pins.spaceZeroSelect_n && !pins.lowerByteWrite_n)
			mem[pins.addr[7:0]] <= pins.dataOut;
		lastD <= dataIn;
	end

	// cycles since select went low
	always_ff @(posedge sys_clk) begin
		if (pins.spaceZeroSelect_n)
			selCnt <= 3'h0;
		else if (selCnt != 3'h7)
			selCnt <= selCnt + 3'h1;
	end

	assign wait_n = !(slowMode && !pins.spaceZeroSelect_n && selCnt < 3'h3);
endmodule : ebsc_mem_model

//--- ebsc_ctrl_tb.sv
// self-checking bench for the external bus state controller
// assumes the memory model on the pins and apb access to registers
`timescale 1ns/100ps
module ebsc_ctrl_tb
	import ebsc_pkg::*;
;
	typedef struct packed {
		logic [2:0]  who;
		logic [31:0] mask;
		logic [31:0] data;
	} ebsc_note_s;
	logic        sys_clk  = 1'b0;
	logic        rst_b    = 1'b0;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  masterReq = 3'h0;
	logic [2:0]  masterDone;
	ebsc_req_s   masterCmd [3];
	logic        fetchReq = 1'b0;
	logic [31:0] readData;
	ebsc_pins_s  pins;
	logic [7:0]  dataIn;
	logic        wait_n;
	logic        busAck_n;
	logic        intPend_n;
	logic        extReq_n = 1'b1;
	logic        intValid = 1'b0;
	logic        slowMode = 1'b0;
	logic [3:0]  intLevel = 4'h0;
	logic [3:0]  intMask  = 4'hf;
	logic [31:0] seed     = 32'h00009723;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cycles   = 0;
	ebsc_note_s  notes [$];

	ebsc_ctrl #(.NUM_MASTERS(3)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .masterReq(masterReq),
		.masterCmd(masterCmd), .fetchReq(fetchReq), .masterDone(masterDone),
		.readData(readData), .pins(pins), .dataIn(dataIn), .wait_n(wait_n),
		.external_bus_request_n(extReq_n), .busAck_n(busAck_n),
		.intSourceValid(intValid), .intLevel(intLevel),
		.interrupt_mask_bits(intMask), .interrupt_pending_out_n(intPend_n));
	ebsc_mem_model MEM (.sys_clk(sys_clk), .pins(pins), .slowMode(slowMode),
		.dataIn(dataIn), .wait_n(wait_n));

	// clock at 25 mhz
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic conclude();
		if (num_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// one apb transfer, setup then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one master request held until its done pulse
	task automatic req(input int i, input logic w, input ebsc_size_e s,
		input logic [31:0] a, input logic [31:0] d, output int lat);
		@(posedge sys_clk);
		masterCmd[i] <= '{w, 1'b0, s, a, d};
		masterReq[i] <= 1'b1;
		lat = 0;
		do begin
			@(negedge sys_clk);
			lat++;
		end while (masterDone[i] !== 1'b1);
		@(posedge sys_clk);
		masterReq[i] <= 1'b0;
	endtask : req

	// completions against the oldest note
	always @(negedge sys_clk) begin
		ebsc_note_s n;
		if (rst_b && masterDone !== 3'h0) begin
			n = notes.pop_front();
			chk("done master", {29'h0, n.who}, {29'h0, masterDone});
			chk("read data", n.data & n.mask, readData & n.mask);
		end
	end

	// pins under a strobe: write data driven, upper address bits of the tests are zero
	always @(negedge sys_clk) begin
		if (rst_b && !pins.lowerByteWrite_n)
			chk("write drive", 32'h0, {31'h0, pins.dataOe_n});
		if (rst_b && (!pins.read_n || !pins.lowerByteWrite_n))
			chk("pin address", 32'h0, {22'h0, pins.addr[17:8]});
	end

	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		logic [31:0] r;
		logic [31:0] d;
		logic        e;
		logic [15:0] rstv [4];
		int          lL, lB, lW, lS, lX;
		for (int i = 0; i < 3; i++)
			masterCmd[i] = '0;
		rstv = '{BUS_CTRL_ONE_RST, BUS_CTRL_TWO_RST, WAIT_CTRL_ONE_RST, RAM_EMU_SEL_RST};
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		// reset values, read back, unmapped refusal
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, 8'(4 * k), 32'h0, r, e);
			chk("reset value", {16'h0, rstv[k]}, r);
		end
		apb(1'b1, BUS_CTRL_ONE_OFS, 32'h0, r, e);
		apb(1'b1, RAM_EMU_SEL_OFS, 32'h0000a5c3, r, e);
		apb(1'b0, RAM_EMU_SEL_OFS, 32'h0, r, e);
		chk("emulation select", 32'h0000a5c3, r);
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		// long write then long, byte and fetch reads
		d = rnd();
		notes.push_back('{3'h1, 32'h0, 32'h0});
		req(0, 1'b1, EBSC_SZ_LONG, 32'h003c0010, d, lW);
		notes.push_back('{3'h1, 32'hffffffff, d});
		req(0, 1'b0, EBSC_SZ_LONG, 32'h003c0010, 32'h0, lL);
		notes.push_back('{3'h1, 32'h000000ff, {24'h0, d[23:16]}});
		req(0, 1'b0, EBSC_SZ_BYTE, 32'h00000012, 32'h0, lB);
		chk("long cycles", 32'h6, 32'(lL - lB));
		fetchReq <= 1'b1;
		notes.push_back('{3'h1, 32'hffffffff, d});
		req(0, 1'b0, EBSC_SZ_BYTE, 32'h00000010, 32'h0, lX);
		fetchReq <= 1'b0;
		// software waits, then the wait pin on top
		apb(1'b1, WAIT_CTRL_ONE_OFS, 32'h2, r, e);
		notes.push_back('{3'h1, 32'h000000ff, {24'h0, d[23:16]}});
		req(0, 1'b0, EBSC_SZ_BYTE, 32'h00000012, 32'h0, lW);
		chk("wait cycles", 32'h2, 32'(lW - lB));
		slowMode <= 1'b1;
		notes.push_back('{3'h1, 32'h000000ff, {24'h0, d[23:16]}});
		req(0, 1'b0, EBSC_SZ_BYTE, 32'h00000012, 32'h0, lS);
		slowMode <= 1'b0;
		chk("pin wait", 32'h1, {31'h0, lS > lW});
		// select extension adds one cycle each side
		apb(1'b1, WAIT_CTRL_ONE_OFS, 32'h0, r, e);
		apb(1'b1, BUS_CTRL_TWO_OFS, 32'h1 << SEL_EXTEND_POS, r, e);
		notes.push_back('{3'h1, 32'h000000ff, {24'h0, d[23:16]}});
		req(0, 1'b0, EBSC_SZ_BYTE, 32'h00000012, 32'h0, lX);
		chk("extend cycles", 32'h2, 32'(lX - lB));
		// read then write: idle count three, two idle cycles pass between calls
		apb(1'b1, BUS_CTRL_TWO_OFS, 32'h3, r, e);
		notes.push_back('{3'h1, 32'h000000ff, {24'h0, d[23:16]}});
		req(0, 1'b0, EBSC_SZ_BYTE, 32'h00000012, 32'h0, lX);
		notes.push_back('{3'h1, 32'h0, 32'h0});
		req(0, 1'b1, EBSC_SZ_BYTE, 32'h00000013, {24'h0, d[23:16]}, lX);
		chk("idle shortfall", 32'h1, 32'(lX - lB));
		apb(1'b1, BUS_CTRL_TWO_OFS, 32'h0, r, e);
		// trace master beats core on a shared edge
		notes.push_back('{3'h4, 32'h000000ff, {24'h0, d[7:0]}});
		notes.push_back('{3'h1, 32'h000000ff, {24'h0, d[15:8]}});
		@(posedge sys_clk);
		masterCmd[2] <= '{1'b0, 1'b0, EBSC_SZ_BYTE, 32'h10, 32'h0};
		masterCmd[0] <= '{1'b0, 1'b0, EBSC_SZ_BYTE, 32'h11, 32'h0};
		masterReq <= 3'h5;
		do @(negedge sys_clk); while (masterDone[2] !== 1'b1);
		@(posedge sys_clk);
		masterReq[2] <= 1'b0;
		do @(negedge sys_clk); while (masterDone[0] !== 1'b1);
		@(posedge sys_clk);
		masterReq[0] <= 1'b0;
		// release to an outside master, pending interrupt, return
		extReq_n <= 1'b0;
		intLevel <= 4'h3;
		intMask <= 4'h3;
		intValid <= 1'b1;
		repeat (4) @(negedge sys_clk);
		chk("bus acknowledge", 32'h0, {31'h0, busAck_n});
		chk("pending at mask", 32'h1, {31'h0, intPend_n});
		@(posedge sys_clk);
		intLevel <= 4'h5;
		repeat (3) @(negedge sys_clk);
		chk("pending above mask", 32'h0, {31'h0, intPend_n});
		@(posedge sys_clk);
		extReq_n <= 1'b1;
		intValid <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("acknowledge off", 32'h1, {31'h0, busAck_n});
		notes.push_back('{3'h1, 32'h000000ff, {24'h0, d[23:16]}});
		req(0, 1'b0, EBSC_SZ_BYTE, 32'h00000013, 32'h0, lX);
		chk("notes left", 32'h0, 32'(notes.size()));
		conclude();
	end
endmodule : ebsc_ctrl_tb
